// ### pbhr_pkg.sv
// Shared constants and types for the primary bus hold and release block
package pbhr_pkg;

    // Input synchroniser shape and reset levels
    localparam int PBHR_SYNC_BITS = 2;
    localparam int PBHR_BIT_PHASE = 0;
    localparam int PBHR_BIT_REQ = 1;
    // Phase level resets high and the active-high request resets inactive
    localparam logic [PBHR_SYNC_BITS-1:0] PBHR_SYNC_RST = 2'h1;

    // Output reset values
    localparam logic PBHR_ACK_N_RST = 1'h1;
    localparam logic PBHR_STROBE_HI_RST = 1'h0;
    localparam logic PBHR_CTL_OE_RST = 1'h1;
    localparam logic PBHR_DATA_OE_RST = 1'h1;
    localparam logic PBHR_PEND_RST = 1'h0;
    localparam logic PBHR_FLUSH_RST = 1'h0;
    localparam logic PBHR_REQ_H1_RST = 1'h0;

    // Timing in phase-one clock cycles
    localparam int PBHR_HOLD_LOW_MIN_H1 = 2;
    localparam int PBHR_ACK_TAIL_H1 = 1;

    typedef enum logic [2:0] {
        PBHR_ST_BUS,
        PBHR_ST_STROBE,
        PBHR_ST_FLOAT,
        PBHR_ST_EXIT
    } pbhr_state_t;

endpackage

// ### pbhr_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pbhr_sync
    import pbhr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [PBHR_SYNC_BITS-1:0] i_async,
    output logic [PBHR_SYNC_BITS-1:0] o_level
);

    typedef struct packed {
        logic [PBHR_SYNC_BITS-1:0] s1;
        logic [PBHR_SYNC_BITS-1:0] s2;
        logic [PBHR_SYNC_BITS-1:0] s3;
        logic [PBHR_SYNC_BITS-1:0] lvl;
    } pbhr_sync_t;

    pbhr_sync_t sync_q;
    pbhr_sync_t sync_d;

    ////////////////////////////////////////////////////////////////////////
    // Stage one feeds only stage two; the level moves when two and three agree
    always_comb begin
        sync_d = sync_q;
        sync_d.s1 = i_async;
        sync_d.s2 = sync_q.s1;
        sync_d.s3 = sync_q.s2;
        sync_d.lvl = (sync_q.s2 & sync_q.s3) | (sync_q.lvl & (sync_q.s2 | sync_q.s3));
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sync_q <= {PBHR_SYNC_RST, PBHR_SYNC_RST, PBHR_SYNC_RST, PBHR_SYNC_RST};
        end else if (i_ce) begin
            sync_q <= sync_d;
        end
    end

    assign o_level = sync_q.lvl;

endmodule

// ### pbhr_phase_sampler.sv
// Phase-one edge finder and phase-timed sampler of the hold request
`timescale 1ns/1ps
module pbhr_phase_sampler
    import pbhr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_phase_lvl,
    input wire logic i_req_lvl,
    output logic o_rise,
    output logic o_fall,
    output logic o_req_h1
);

    typedef struct packed {
        logic phase_prev;
        logic req_h1;
    } pbhr_samp_t;

    pbhr_samp_t samp_q;
    pbhr_samp_t samp_d;
    logic fall;

    assign fall = samp_q.phase_prev & ~i_phase_lvl;

    ////////////////////////////////////////////////////////////////////////
    // The request is taken only at a phase-one fall, so a late change waits a cycle
    always_comb begin
        samp_d = samp_q;
        samp_d.phase_prev = i_phase_lvl;
        if (fall) begin
            samp_d.req_h1 = i_req_lvl;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            // Edge memory starts at the synchroniser's reset level: no false edge
            samp_q <= {PBHR_SYNC_RST[PBHR_BIT_PHASE], PBHR_REQ_H1_RST};
        end else if (i_ce) begin
            samp_q <= samp_d;
        end
    end

    assign o_rise = ~samp_q.phase_prev & i_phase_lvl & i_ce;
    assign o_fall = fall & i_ce;
    assign o_req_h1 = samp_q.req_h1;

endmodule

// ### pbhr_top.sv
// Primary bus hold and release controller
`timescale 1ns/1ps
module pbhr_top
    import pbhr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_phase_one_clock,
    input wire logic i_hold_req_n,
    input wire logic i_hold_ignore_bit,
    input wire logic i_post_enable,
    input wire logic i_core_busy,
    input wire logic i_core_req,
    input wire logic i_core_wr,
    output logic o_bus_release_ack_n,
    output logic o_strobe_force_hi,
    output logic o_ctl_oe,
    output logic o_data_oe,
    output logic o_core_bus_en,
    output logic o_core_stall,
    output logic o_write_posted,
    output logic o_post_flush
);

    typedef struct packed {
        pbhr_state_t st;
        logic ack_n;
        logic strobe_hi;
        logic ctl_oe;
        logic data_oe;
        logic pend;
        logic flush;
    } pbhr_main_t;

    pbhr_main_t m_q;
    pbhr_main_t m_d;

    logic [PBHR_SYNC_BITS-1:0] pins_async;
    logic [PBHR_SYNC_BITS-1:0] pins_lvl;
    logic rise_ev;
    logic fall_ev;
    logic req_h1;
    logic in_hold;
    logic want_hold;
    logic can_post;
    logic core_take;

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning

    // Request is active low at the pin; the sampler wants it active high
    assign pins_async[PBHR_BIT_PHASE] = i_phase_one_clock;
    assign pins_async[PBHR_BIT_REQ] = ~i_hold_req_n;

    pbhr_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async(pins_async),
        .o_level(pins_lvl)
    );

    pbhr_phase_sampler u_samp (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_phase_lvl(pins_lvl[PBHR_BIT_PHASE]),
        .i_req_lvl(pins_lvl[PBHR_BIT_REQ]),
        .o_rise(rise_ev),
        .o_fall(fall_ev),
        .o_req_h1(req_h1)
    );

    ////////////////////////////////////////////////////////////////////////
    // Core side arbitration

    assign in_hold = (m_q.st != PBHR_ST_BUS);
    // A request pulse from the master that ends before a fall is never seen
    assign want_hold = req_h1 & ~i_hold_ignore_bit;
    assign can_post = i_core_wr & i_post_enable & ~m_q.pend;

    always_comb begin
        o_core_stall = 1'h0;
        if (i_core_req) begin
            if (in_hold) begin
                o_core_stall = ~can_post;
            end else if (m_q.pend || m_q.flush) begin
                // Posted write drains before any new access
                o_core_stall = 1'h1;
            end
        end
    end

    assign core_take = i_core_req & ~o_core_stall & i_ce;
    assign o_core_bus_en = ~in_hold & ~m_q.pend;

    ////////////////////////////////////////////////////////////////////////
    // Hold sequencer

    always_comb begin
        m_d = m_q;
        m_d.flush = 1'h0;
        // Data lines follow phase-one rises only
        if (rise_ev) begin
            m_d.data_oe = ~in_hold;
        end
        if (in_hold && core_take && i_core_wr) begin
            m_d.pend = 1'h1;
        end
        if (!in_hold && m_q.pend && !m_q.flush) begin
            m_d.flush = 1'h1;
            m_d.pend = 1'h0;
        end
        case (m_q.st)
            PBHR_ST_BUS: begin
                // An access already on the bus finishes before release
                if (fall_ev && want_hold && !i_core_busy) begin
                    m_d.st = PBHR_ST_STROBE;
                    m_d.ack_n = 1'h0;
                    m_d.strobe_hi = 1'h1;
                end
            end
            PBHR_ST_STROBE: begin
                if (fall_ev) begin
                    m_d.ctl_oe = 1'h0;
                    m_d.st = PBHR_ST_FLOAT;
                end
            end
            PBHR_ST_FLOAT: begin
                if (fall_ev) begin
                    if (i_hold_ignore_bit) begin
                        m_d.st = PBHR_ST_BUS;
                        m_d.ack_n = 1'h1;
                        m_d.ctl_oe = 1'h1;
                        m_d.strobe_hi = 1'h0;
                    end else if (!req_h1) begin
                        m_d.st = PBHR_ST_EXIT;
                    end
                end
            end
            PBHR_ST_EXIT: begin
                if (fall_ev) begin
                    m_d.st = PBHR_ST_BUS;
                    m_d.ack_n = 1'h1;
                    m_d.ctl_oe = 1'h1;
                    m_d.strobe_hi = 1'h0;
                end
            end
            default: begin
                m_d.st = PBHR_ST_BUS;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            m_q.st <= PBHR_ST_BUS;
            m_q.ack_n <= PBHR_ACK_N_RST;
            m_q.strobe_hi <= PBHR_STROBE_HI_RST;
            m_q.ctl_oe <= PBHR_CTL_OE_RST;
            m_q.data_oe <= PBHR_DATA_OE_RST;
            m_q.pend <= PBHR_PEND_RST;
            m_q.flush <= PBHR_FLUSH_RST;
        end else if (i_ce) begin
            m_q <= m_d;
        end
    end

    assign o_bus_release_ack_n = m_q.ack_n;
    assign o_strobe_force_hi = m_q.strobe_hi;
    assign o_ctl_oe = m_q.ctl_oe;
    assign o_data_oe = m_q.data_oe;
    assign o_write_posted = m_q.pend;
    assign o_post_flush = m_q.flush;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_enter;
        m_q.st == PBHR_ST_BUS && fall_ev && want_hold && !i_core_busy && i_ce;
    endsequence

    sequence s_req_gone;
        m_q.st == PBHR_ST_FLOAT && fall_ev && !req_h1 && !i_hold_ignore_bit && i_ce;
    endsequence

    sequence s_strobe_step;
        m_q.st == PBHR_ST_STROBE && fall_ev && i_ce;
    endsequence

    sequence s_exit_step;
        m_q.st == PBHR_ST_EXIT && fall_ev && i_ce;
    endsequence

    sequence s_flush_due;
        !in_hold && m_q.pend && !m_q.flush && i_ce;
    endsequence

    a_ack_on_fall: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $changed(m_q.ack_n) |-> $past(fall_ev))
        else $error("acknowledge moved without a phase-one fall");

    a_strobe_first: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_enter |=> m_q.strobe_hi && m_q.ctl_oe && !m_q.ack_n)
        else $error("strobe not driven high first on hold entry");

    a_ctl_float: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $fell(m_q.ctl_oe) |-> $past(fall_ev) && $past(m_q.st) == PBHR_ST_STROBE)
        else $error("control drivers floated at the wrong moment");

    a_data_rise: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $changed(m_q.data_oe) |-> $past(rise_ev))
        else $error("data enable moved without a phase-one rise");

    a_ctl_return: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(m_q.ctl_oe) |-> $past(fall_ev) && m_q.st == PBHR_ST_BUS && m_q.ack_n)
        else $error("control drivers returned out of step");

    a_no_core_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !m_q.ack_n |-> !o_core_bus_en)
        else $error("core bus enabled during hold");

    a_ack_tail: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_req_gone |=> !m_q.ack_n && m_q.st == PBHR_ST_EXIT)
        else $error("acknowledge released without its tail cycle");

    a_ignore_exit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        m_q.st == PBHR_ST_FLOAT && fall_ev && i_hold_ignore_bit && i_ce
        |=> m_q.ack_n && m_q.st == PBHR_ST_BUS)
        else $error("hold-ignore did not end the hold");

    a_ignore_refuse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        m_q.st == PBHR_ST_BUS && i_hold_ignore_bit && i_ce |=> m_q.st == PBHR_ST_BUS)
        else $error("hold entered while hold-ignore set");

    a_read_stall: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        in_hold && i_core_req && !i_core_wr |-> o_core_stall)
        else $error("read passed during hold");

    a_second_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        in_hold && m_q.pend && i_core_req |-> o_core_stall)
        else $error("second write passed during hold");

    a_sync_h1: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $changed(req_h1) |-> $past(fall_ev))
        else $error("request sample moved off a phase-one fall");

    a_strobe_step: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_strobe_step |=> m_q.st == PBHR_ST_FLOAT && !m_q.ctl_oe)
        else $error("control drivers still on after the strobe step");

    a_exit_return: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_exit_step |=> m_q.st == PBHR_ST_BUS && m_q.ack_n
            && m_q.ctl_oe && !m_q.strobe_hi)
        else $error("hold exit did not restore the drivers");

    a_strobe_held: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !m_q.ack_n |-> m_q.strobe_hi)
        else $error("strobe not held high while acknowledged");

    a_data_float: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        rise_ev && in_hold |=> !m_q.data_oe)
        else $error("data bus still driven after a rise in hold");

    a_data_back: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        rise_ev && !in_hold |=> m_q.data_oe)
        else $error("data bus not returned at a rise outside hold");

    a_flush_due: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_flush_due |=> m_q.flush && !m_q.pend)
        else $error("posted write not issued after hold");

    a_flush_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        m_q.flush && i_ce |=> !m_q.flush)
        else $error("posted write issue lasted more than a cycle");

    a_drain_stall: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !in_hold && (m_q.pend || m_q.flush) && i_core_req |-> o_core_stall)
        else $error("core access passed a draining posted write");

    a_posted_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        m_q.pend |-> !o_core_bus_en)
        else $error("core bus enabled while a write is posted");

    a_busy_entry: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        m_q.st == PBHR_ST_BUS && i_core_busy && i_ce |=> m_q.st == PBHR_ST_BUS)
        else $error("hold entered during a core bus access");

    a_req_sample: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fall_ev |=> req_h1 == $past(pins_lvl[PBHR_BIT_REQ]))
        else $error("request not sampled at a phase-one fall");

endmodule

// ### pbhr_master_model.sv
// External bus master model that raises hold requests
`timescale 1ns/1ps
module pbhr_master_model #(
    parameter int MIN_LOW = 16
) (
    input wire logic i_mclk,
    input wire logic i_want,
    output logic o_hold_req_n
);
    int low_cnt = 0;
    logic req_n_q = 1'h1;
    logic want_s;
    assign o_hold_req_n = req_n_q;
    // Low time is counted so a short want never gives a runt request
    always @(posedge i_mclk) begin
        // Want is taken at the edge so the bench's own update cannot race it
        want_s = i_want;
        #1;
        if (want_s || (!req_n_q && low_cnt < MIN_LOW)) begin
            req_n_q = 1'h0;
            low_cnt = low_cnt + 1;
        end else begin
            req_n_q = 1'h1;
            low_cnt = 0;
        end
    end
endmodule

// ### tb.sv
// Self-checking bench for the primary bus hold and release block
`timescale 1ns/1ps
module tb;
    import pbhr_pkg::*;
    logic i_mclk = 1'h0;
    logic i_rst_n = 1'h0;
    logic ph = 1'h0;
    logic want = 1'h0;
    logic ign = 1'h0;
    logic post = 1'h0;
    logic busy = 1'h0;
    logic creq = 1'h0;
    logic cwr = 1'h0;
    wire logic req_n;
    logic ack_n, force_hi, ctl_oe, data_oe, bus_en, stall, posted, flush;
    int n_mismatch = 0;
    int compares = 0;
    ////////////////////////////////
    always #10 i_mclk = ~i_mclk;
    // Phase clock of 8 mclk periods, edges kept off the mclk rising edges
    always #80 ph = ~ph;
    pbhr_master_model #(.MIN_LOW(PBHR_HOLD_LOW_MIN_H1 * 8)) master (
        .i_mclk(i_mclk), .i_want(want), .o_hold_req_n(req_n));
    pbhr_top DUT (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'h1),
        .i_phase_one_clock(ph), .i_hold_req_n(req_n),
        .i_hold_ignore_bit(ign), .i_post_enable(post),
        .i_core_busy(busy), .i_core_req(creq), .i_core_wr(cwr),
        .o_bus_release_ack_n(ack_n), .o_strobe_force_hi(force_hi),
        .o_ctl_oe(ctl_oe), .o_data_oe(data_oe), .o_core_bus_en(bus_en),
        .o_core_stall(stall), .o_write_posted(posted), .o_post_flush(flush));
    ////////////////////////////////
    task automatic step();
        @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait: 0 ack, 1 ctl_oe, 2 data_oe, 3 flush
    task automatic wait_on(input int sel, input logic v);
        logic s;
        for (int i = 0; i < 200; i++) begin
            s = sel == 0 ? ack_n : sel == 1 ? ctl_oe : sel == 2 ? data_oe : flush;
            if (s === v) return;
            step();
        end
        chk(s, v);
    endtask
    task automatic final_report();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic enter();
        want = 1'h1;
        wait_on(0, 1'h0);
        chk(force_hi, 1'h1);
        chk(ctl_oe, 1'h1);
        wait_on(1, 1'h0);
        chk(data_oe, 1'h0);
        chk(ack_n, 1'h0);
    endtask
    task automatic idle();
        want = 1'h0;
        while (req_n !== 1'h1) step();
        repeat (24) step();
    endtask
    ////////////////////////////////
    task automatic t_hold();
        enter();
        want = 1'h0;
        while (req_n !== 1'h1) step();
        // Acknowledge must outlast the request by one phase cycle
        for (int i = 0; i < PBHR_ACK_TAIL_H1 * 8; i++) begin
            chk(ack_n, 1'h0);
            step();
        end
        wait_on(0, 1'h1);
        chk(ctl_oe, 1'h1);
        chk(force_hi, 1'h0);
        wait_on(2, 1'h1);
    endtask
    task automatic t_core();
        enter();
        chk(stall, 1'h0);
        creq = 1'h1;
        #5;
        chk(stall, 1'h1);
        chk(bus_en, 1'h0);
        step();
        cwr = 1'h1;
        post = 1'h1;
        #5;
        chk(stall, 1'h0);
        step();
        chk(posted, 1'h1);
        chk(stall, 1'h1);
        creq = 1'h0;
        cwr = 1'h0;
        post = 1'h0;
        want = 1'h0;
        wait_on(0, 1'h1);
        wait_on(3, 1'h1);
        chk(posted, 1'h0);
        step();
        chk(flush, 1'h0);
        wait_on(2, 1'h1);
    endtask
    task automatic t_ignore();
        ign = 1'h1;
        want = 1'h1;
        for (int i = 0; i < 40; i++) begin
            step();
            chk(ack_n, 1'h1);
        end
        idle();
        ign = 1'h0;
        enter();
        ign = 1'h1;
        wait_on(0, 1'h1);
        chk(ctl_oe, 1'h1);
        chk(force_hi, 1'h0);
        for (int i = 0; i < 40; i++) begin
            step();
            chk(ack_n, 1'h1);
        end
        idle();
        ign = 1'h0;
    endtask
    // Hold entry waits until the core's bus access has finished
    task automatic t_busy();
        busy = 1'h1;
        want = 1'h1;
        for (int i = 0; i < 40; i++) begin
            step();
            chk(ack_n, 1'h1);
        end
        busy = 1'h0;
        wait_on(0, 1'h0);
        chk(force_hi, 1'h1);
        idle();
        wait_on(0, 1'h1);
        wait_on(2, 1'h1);
    endtask
    ////////////////////////////////
    initial begin
        repeat (16) step();
        i_rst_n = 1'h1;
        step();
        chk({1'h0, ack_n, force_hi, ctl_oe, data_oe, posted, flush, bus_en}, 8'h59);
        t_hold();
        t_hold();
        t_core();
        t_ignore();
        t_busy();
        final_report();
    end
    // Whole run needs a few hundred cycles
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
endmodule
